//--- core/eea_pkg.sv
// Package for the data EEPROM access controller: register map, field
// positions, key values, write timing and the state record.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
package eea_pkg;

    // ========================================================
    // Register map (byte addresses on APB)
    // ========================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_ADDR = 8'h0c;
    localparam logic [7:0] ADDR_FLAG = 8'h10;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int CTRL_RD = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_WR_EN = 2;
    localparam int CTRL_WR_ABORT = 3;
    localparam int FLAG_DONE = 0;

    // ========================================================
    // Array, keys and reset values
    // ========================================================
    localparam int DEPTH = 256;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ========================================================
    // Write timing
    // ========================================================
    localparam int WRITE_TIME_US = 4000;
    localparam int CLK_MHZ = 250;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 20;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 20'h0_0000;

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_ERASE,
        WR_PROG
    } eea_wr_state_t;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_HALF,
        KEY_ARMED
    } eea_key_t;

    typedef struct packed {
        logic rd_start;
        logic wr_start;
        logic wr_enable;
        logic wr_abort;
        logic wr_done;
        logic [7:0] data;
        logic [7:0] addr;
        eea_wr_state_t wr_state;
        eea_key_t key;
        logic [TIMER_W-1:0] timer;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic clear_s1;
        logic clear_s2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } eea_state_t;

endpackage : eea_pkg

//--- core/eea_ctrl.sv
// Data EEPROM access controller: 256-byte array reached only through
// control, unlock, data, address and flag registers on APB.
// Assumes pclk at 250 MHz, presetn as power-up reset, an asynchronous
// active-low master clear pin and a watchdog reset pulse on pclk.
//
// Behaviour
// [R1] 256 bytes, 8-bit address 00 to ff
// [R2] One byte per access via data/address
// [R3] Array reachable only through these registers
// [R4] Byte write erases, then programs
// [R5] Internal timer sets write length
// [R6] Unlock port stores nothing, reads zero
// [R7] Start bits set-only by software
// [R8] Hardware clears start bits on completion
// [R9] Write refused unless write enable set
// [R10] Power-up clears write enable
// [R11] Reset during write sets abort flag
// [R12] Reset zeroes data and address registers
// [R13] Done flag set on completion, software clears
// [R14] Write starts only after key sequence
// [R15] Read data ready next cycle
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module eea_ctrl #(
    parameter int WRITE_CYCLES = eea_pkg::WRITE_CYCLES
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Other reset causes
    input wire logic master_clear_reset_n,
    input wire logic watchdog_timer_reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status
    output logic nvm_write_done_flag,
    output logic write_busy
);

    // ========================================================
    // Timing
    // ========================================================
    // Half the write time for erase, half for programming
    // Timer counts enabled cycles only, so a low ce stretches the write
    localparam int HALF_CYCLES = (WRITE_CYCLES / 2 < 1) ? 1 : WRITE_CYCLES / 2;
    localparam logic [eea_pkg::TIMER_W-1:0] HALF_LOAD =
        eea_pkg::TIMER_W'(HALF_CYCLES - 1);

    // ========================================================
    // State
    // ========================================================
    eea_pkg::eea_state_t s_q;
    eea_pkg::eea_state_t s_d;
    logic [7:0] mem [eea_pkg::DEPTH];  // [R1]
    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] mem_rd;
    logic access;
    logic soft_rst;
    logic [7:0] wbyte;
    logic [31:0] rdata;
    logic err;

    // Combinational read keeps the read latency at one cycle
    // Array read at the address register only
    assign mem_rd = mem[s_q.addr];  // [R3]

    // ========================================================
    // Next-state logic
    // ========================================================
    always_comb
    begin
        s_d = s_q;
        mem_we = 1'b0;
        mem_wa = s_q.wr_addr;
        mem_wd = eea_pkg::ERASED_BYTE;
        access = psel && penable && !s_q.pready;
        wbyte = pwdata[7:0];
        rdata = eea_pkg::WORD_ZERO;
        err = 1'b0;

        // Master clear pin passes two flops first
        s_d.clear_s1 = master_clear_reset_n;
        s_d.clear_s2 = s_q.clear_s1;
        // Watchdog reset is already on pclk and needs no synchroniser
        soft_rst = !s_q.clear_s2 || watchdog_timer_reset;

        // A read during a write sees the old byte or the erased value
        // Read completes one cycle after it is requested
        if (s_q.rd_start)
        begin
            s_d.data = mem_rd;  // [R15]
            s_d.rd_start = 1'b0;  // [R8]
        end

        // Self-timed erase then program
        case (s_q.wr_state)
            eea_pkg::WR_ERASE:
            begin
                if (s_q.timer == eea_pkg::TIMER_ZERO)
                begin
                    mem_we = 1'b1;  // [R4]
                    mem_wd = eea_pkg::ERASED_BYTE;
                    s_d.timer = HALF_LOAD;  // [R5]
                    s_d.wr_state = eea_pkg::WR_PROG;
                end
                else
                begin
                    s_d.timer = s_q.timer - 1'b1;
                end
            end
            eea_pkg::WR_PROG:
            begin
                if (s_q.timer == eea_pkg::TIMER_ZERO)
                begin
                    mem_we = 1'b1;  // [R4]
                    mem_wd = s_q.wr_data;
                    s_d.wr_start = 1'b0;  // [R8]
                    s_d.wr_state = eea_pkg::WR_IDLE;
                end
                else
                begin
                    s_d.timer = s_q.timer - 1'b1;  // [R5]
                end
            end
            default:
            begin
                s_d.wr_state = eea_pkg::WR_IDLE;
            end
        endcase

        // Register access, one wait state
        // Reads leave the key tracker alone; only mapped writes and master clear or watchdog disarm it
        s_d.pready = access;
        s_d.pslverr = 1'b0;
        if (access)
        begin
            if (paddr == eea_pkg::ADDR_CTRL)
            begin
                rdata[eea_pkg::CTRL_RD] = s_q.rd_start;
                rdata[eea_pkg::CTRL_WR] = s_q.wr_start;
                rdata[eea_pkg::CTRL_WR_EN] = s_q.wr_enable;
                rdata[eea_pkg::CTRL_WR_ABORT] = s_q.wr_abort;
            end
            else if (paddr == eea_pkg::ADDR_UNLOCK)
            begin
                rdata = eea_pkg::WORD_ZERO;  // [R6]
            end
            else if (paddr == eea_pkg::ADDR_DATA)
            begin
                rdata[7:0] = s_q.data;  // [R2]
            end
            else if (paddr == eea_pkg::ADDR_ADDR)
            begin
                rdata[7:0] = s_q.addr;  // [R2]
            end
            else if (paddr == eea_pkg::ADDR_FLAG)
            begin
                rdata[eea_pkg::FLAG_DONE] = s_q.wr_done;
            end
            else
            begin
                err = 1'b1;
            end
            s_d.prdata = pwrite ? eea_pkg::WORD_ZERO : rdata;
            s_d.pslverr = err;
        end

        if (access && pwrite && !err)
        begin
            // Any mapped write other than the key steps disarms the unlock
            s_d.key = eea_pkg::KEY_IDLE;  // [R14]
            if (paddr == eea_pkg::ADDR_UNLOCK)
            begin
                // Port holds nothing; it only steps the key tracker
                if (wbyte == eea_pkg::KEY_FIRST)
                begin
                    s_d.key = eea_pkg::KEY_HALF;  // [R6] [R14]
                end
                else if (wbyte == eea_pkg::KEY_SECOND
                         && s_q.key == eea_pkg::KEY_HALF)
                begin
                    s_d.key = eea_pkg::KEY_ARMED;  // [R14]
                end
            end
            else if (paddr == eea_pkg::ADDR_CTRL)
            begin
                s_d.wr_enable = pwdata[eea_pkg::CTRL_WR_EN];
                s_d.wr_abort = pwdata[eea_pkg::CTRL_WR_ABORT];
                // Zeros leave start bits alone, so no abort by software
                if (pwdata[eea_pkg::CTRL_RD])
                begin
                    s_d.rd_start = 1'b1;  // [R7]
                end
                if (pwdata[eea_pkg::CTRL_WR] && !s_q.wr_start
                    && s_q.wr_enable
                    && s_q.key == eea_pkg::KEY_ARMED)
                begin
                    // Latch address and data so later edits cannot corrupt
                    s_d.wr_start = 1'b1;  // [R7] [R9] [R14]
                    s_d.wr_addr = s_q.addr;
                    s_d.wr_data = s_q.data;
                    s_d.timer = HALF_LOAD;  // [R5]
                    s_d.wr_state = eea_pkg::WR_ERASE;
                end
            end
            else if (paddr == eea_pkg::ADDR_DATA)
            begin
                s_d.data = wbyte;  // [R2]
            end
            else if (paddr == eea_pkg::ADDR_ADDR)
            begin
                s_d.addr = wbyte;  // [R1] [R2]
            end
            else if (paddr == eea_pkg::ADDR_FLAG)
            begin
                // Software clears by writing zero
                s_d.wr_done = s_q.wr_done & pwdata[eea_pkg::FLAG_DONE];
            end
        end

        // Completion sets the flag after any clear: set wins
        // A reset in the final cycle counts as an abort, not a finish
        if (s_q.wr_state == eea_pkg::WR_PROG
            && s_q.timer == eea_pkg::TIMER_ZERO
            && !soft_rst)
        begin
            s_d.wr_done = 1'b1;  // [R13]
        end

        // Array write is dropped, so an aborted byte may read erased;
        // the done flag is kept so a finished write is not lost
        // Master clear or watchdog: abort, flag, zero the registers
        if (soft_rst)
        begin
            if (s_q.wr_state != eea_pkg::WR_IDLE)
            begin
                s_d.wr_abort = 1'b1;  // [R11]
            end
            mem_we = 1'b0;
            s_d.rd_start = 1'b0;
            s_d.wr_start = 1'b0;
            s_d.wr_enable = 1'b0;
            s_d.data = eea_pkg::BYTE_ZERO;  // [R12]
            s_d.addr = eea_pkg::BYTE_ZERO;  // [R12]
            s_d.wr_state = eea_pkg::WR_IDLE;
            s_d.key = eea_pkg::KEY_IDLE;
            s_d.timer = eea_pkg::TIMER_ZERO;
        end
    end

    // ========================================================
    // State register
    // ========================================================
    // Power-up clears every bit, write enable included
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;  // [R10] [R12]
            s_q.wr_state <= eea_pkg::WR_IDLE;
            s_q.key <= eea_pkg::KEY_IDLE;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Array
    // ========================================================
    // No reset: contents are nonvolatile
    // One write port: erase and program never fall in one cycle
    always_ff @(posedge pclk)
    begin
        if (ce && mem_we)
        begin
            mem[mem_wa] <= mem_wd;  // [R4]
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    // All outputs come straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign nvm_write_done_flag = s_q.wr_done;  // [R13]
    assign write_busy = s_q.wr_start;

endmodule : eea_ctrl

//--- sim/eea_ctrl_chk.sv
// Checker for the data EEPROM controller, watching top-level ports only.
// Assumes pclk is the only clock; properties that need ce name it.
`timescale 1ns/1ps
module eea_ctrl_chk #(
    parameter int WRITE_CYCLES = 8
) (
    // Clock, enable and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic master_clear_reset_n,
    input wire logic watchdog_timer_reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Status
    input wire logic nvm_write_done_flag,
    input wire logic write_busy
);
    // ========================================================
    // Helpers
    // ========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    logic wr_ctl;
    logic wr_flg;
    // Decode done once so properties stay short
    assign mapped = paddr inside {eea_pkg::ADDR_CTRL, eea_pkg::ADDR_UNLOCK,
        eea_pkg::ADDR_DATA, eea_pkg::ADDR_ADDR, eea_pkg::ADDR_FLAG};
    assign wr_ctl = psel && penable && pwrite && paddr == eea_pkg::ADDR_CTRL;
    assign wr_flg = psel && penable && pwrite && paddr == eea_pkg::ADDR_FLAG;
    sequence acc_s;
        psel && penable && !pready && ce;
    endsequence
    sequence rsp_s;
        pready && psel && !pwrite;
    endsequence

    // ========================================================
    // Assertions
    // ========================================================
    answer_one_wait_a: assert property (acc_s |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready && ce |=> !pready)
        else $error("pready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (pready && psel && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    unlock_zero_a: assert property (rsp_s ##0 paddr == eea_pkg::ADDR_UNLOCK
        |-> prdata == eea_pkg::WORD_ZERO)
        else $error("unlock port read not zero");
    busy_length_a: assert property ($rose(write_busy) |=> write_busy[*4])
        else $error("write ended too early");
    start_cause_a: assert property ($rose(write_busy)
        |-> $past(wr_ctl && pwdata[eea_pkg::CTRL_WR]))
        else $error("write started without a start write");
    done_cause_a: assert property ($rose(nvm_write_done_flag)
        |-> $fell(write_busy))
        else $error("done flag without write completion");
    done_hold_a: assert property (nvm_write_done_flag && !wr_flg
        |=> nvm_write_done_flag)
        else $error("done flag dropped by itself");
    watchdog_abort_a: assert property (watchdog_timer_reset && ce
        |=> !write_busy)
        else $error("watchdog did not stop the write");
endmodule : eea_ctrl_chk

bind eea_ctrl eea_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_eea_ctrl_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .master_clear_reset_n(master_clear_reset_n),
    .watchdog_timer_reset(watchdog_timer_reset), .psel(psel),
    .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .nvm_write_done_flag(nvm_write_done_flag), .write_busy(write_busy));

//--- sim/eea_core_mdl.sv
// Processor-core model: APB master that reaches the EEPROM registers.
// Assumes the slave answers with pready; only the bench timeout ends a wait.
`timescale 1ns/1ps
module eea_core_mdl (
    // Clock
    input wire logic pclk,
    // Requests
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answers
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic err;
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err = 1'b0;
    end
    // One APB transfer; released address and data lines show inverted values
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask : rd
    // Full write: address and data, then enable, then the two keys, then the start bit
    task automatic start_write(input logic [7:0] a, input logic [31:0] d);
        wr(eea_pkg::ADDR_ADDR, {24'h00_0000, a});
        wr(eea_pkg::ADDR_DATA, d);
        wr(eea_pkg::ADDR_CTRL, 32'h0000_0004);
        wr(eea_pkg::ADDR_UNLOCK, {24'h00_0000, eea_pkg::KEY_FIRST});
        wr(eea_pkg::ADDR_UNLOCK, {24'h00_0000, eea_pkg::KEY_SECOND});
        wr(eea_pkg::ADDR_CTRL, 32'h0000_0006);
    endtask : start_write
endmodule : eea_core_mdl

//--- sim/eea_ctrl_test.sv
// Self-checking bench for the data EEPROM controller.
// Assumes the core model above drives APB; write timer shortened to 16.
`timescale 1ns/1ps
module eea_ctrl_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic master_clear_reset_n = 1'b1;
    logic watchdog_timer_reset = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, done, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int fails = 0;
    int total_checks = 0;

    // ========================================================
    // Clock, design and core model
    // ========================================================
    always #2 pclk = ~pclk;
    eea_ctrl #(.WRITE_CYCLES(16)) u_eea_ctrl (.pclk(pclk),
        .presetn(presetn), .ce(ce),
        .master_clear_reset_n(master_clear_reset_n),
        .watchdog_timer_reset(watchdog_timer_reset), .psel(psel),
        .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nvm_write_done_flag(done),
        .write_busy(busy));
    eea_core_mdl core (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ========================================================
    // Scenarios
    // ========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic t_reset;
        core.rd(eea_pkg::ADDR_CTRL, q);
        chk(q, 32'h0);
        core.rd(eea_pkg::ADDR_DATA, q);
        chk(q, 32'h0);
        core.wr(eea_pkg::ADDR_UNLOCK, 32'h55);
        core.rd(eea_pkg::ADDR_UNLOCK, q);
        chk(q, 32'h0);
        core.rd(8'h20, q);
        chk({q[31:1], core.err}, 32'h1);
    endtask : t_reset
    // Start bit without keys, then keys without enable
    task automatic t_refuse;
        core.wr(eea_pkg::ADDR_CTRL, 32'h4);
        core.wr(eea_pkg::ADDR_CTRL, 32'h6);
        core.rd(eea_pkg::ADDR_CTRL, q);
        chk(q, 32'h4);
        core.wr(eea_pkg::ADDR_CTRL, 32'h0);
        core.wr(eea_pkg::ADDR_UNLOCK, 32'h55);
        core.wr(eea_pkg::ADDR_UNLOCK, 32'haa);
        core.wr(eea_pkg::ADDR_CTRL, 32'h2);
        core.rd(eea_pkg::ADDR_CTRL, q);
        chk(q, 32'h0);
    endtask : t_refuse
    // Rewriting one byte must erase first, so the old value leaves no trace
    task automatic t_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        core.start_write(a, d);
        core.wr(eea_pkg::ADDR_CTRL, 32'h4);
        core.rd(eea_pkg::ADDR_CTRL, q);
        chk(q, 32'h6);
        for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge pclk);
        chk({31'h0, done}, 32'h1);
        core.wr(eea_pkg::ADDR_ADDR, {24'h0, a});
        core.wr(eea_pkg::ADDR_CTRL, 32'h1);
        core.rd(eea_pkg::ADDR_CTRL, q);
        chk(q, 32'h0);
        core.rd(eea_pkg::ADDR_DATA, q);
        chk(q, d);
        core.wr(eea_pkg::ADDR_FLAG, 32'h0);
        core.rd(eea_pkg::ADDR_FLAG, q);
        chk(q, 32'h0);
    endtask : t_write
    // Clock enable low mid-write: timer and flags must hold
    task automatic t_freeze;
        int n;
        core.start_write(8'h40, 32'h66);
        ce <= 1'b0;
        repeat (40) @(posedge pclk);
        chk({31'h0, busy}, 32'h1);
        ce <= 1'b1;
        for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge pclk);
        chk({31'h0, done}, 32'h1);
        core.wr(eea_pkg::ADDR_FLAG, 32'h0);
    endtask : t_freeze
    // Master clear in the programming half (timer of 16), then watchdog
    task automatic t_abort;
        core.start_write(8'h10, 32'h77);
        repeat (9) @(posedge pclk);
        master_clear_reset_n <= 1'b0;
        repeat (4) @(posedge pclk);
        master_clear_reset_n <= 1'b1;
        repeat (3) @(posedge pclk);
        core.rd(eea_pkg::ADDR_CTRL, q);
        chk(q, 32'h8);
        core.rd(eea_pkg::ADDR_ADDR, q);
        chk(q, 32'h0);
        // Erase already done, programming cut: the byte reads erased
        core.wr(eea_pkg::ADDR_ADDR, 32'h10);
        core.wr(eea_pkg::ADDR_CTRL, 32'h1);
        core.rd(eea_pkg::ADDR_DATA, q);
        chk(q, 32'hff);
        core.start_write(8'h20, 32'h99);
        repeat (5) @(posedge pclk);
        watchdog_timer_reset <= 1'b1;
        @(posedge pclk);
        watchdog_timer_reset <= 1'b0;
        core.rd(eea_pkg::ADDR_DATA, q);
        chk({q[31:1], busy}, 32'h0);
        core.rd(eea_pkg::ADDR_CTRL, q);
        chk(q, 32'h8);
    endtask : t_abort

    // ========================================================
    // Sequence and watchdog
    // ========================================================
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_reset();
        t_refuse();
        t_write(8'hff, 32'h5a);
        t_write(8'hff, 32'h81);
        t_write(8'h00, 32'h3c);
        t_freeze();
        t_abort();
        give_verdict();
    end
    // Run needs a few hundred cycles; this margin only catches hangs
    initial
    begin
        repeat (5000) @(posedge pclk);
        fails++;
        give_verdict();
    end
endmodule : eea_ctrl_test
